// *** src/fnps_pkg.sv ***
// Constants, register map and state types of the frame-number and periodic-start block.
// Function
// - Count frame number on every remaining-counter reload.
// - Frame number wraps to zero after FFFFh.
// - Increment frame number when entering running state.
// - Increment, send SOF, then store to HCCA.
// - Set start-of-frame flag after HCCA store.
// - Frame number readable as 16-bit timing reference.
// - Hardware reset clears periodic-start threshold.
// - Threshold match gives periodic lists priority.
// - Finish current control/bulk transaction before periodic.
// - Decrement each bit time, reload after zero.
// - Reload value is the frame interval field.
package fnps_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned FNPS_ADDR_W   = 8;
  localparam int unsigned FNPS_DATA_W   = 32;
  localparam int unsigned FNPS_FRAME_W  = 16;
  localparam int unsigned FNPS_REMAIN_W = 14;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  FRAME_COUNT_OFFSET        = 8'h3c;
  localparam logic [7:0]  PERIODIC_THRESHOLD_OFFSET = 8'h40;
  localparam logic [15:0] FRAME_COUNT_RESET         = 16'h0000;
  localparam logic [13:0] THRESHOLD_RESET           = 14'h0000;
  localparam logic [13:0] REMAINING_RESET           = 14'h0000;
  localparam logic [15:0] FRAME_COUNT_MAX           = 16'hffff;
  localparam logic [13:0] NOMINAL_FRAME_INTERVAL    = 14'h2edf;
  localparam logic [31:0] UNMAPPED_READ_VALUE       = 32'h0000_0000;
  localparam int unsigned SOF_FLAG_BIT              = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FNPS_SEQ_IDLE,
    FNPS_SEQ_SOF,
    FNPS_SEQ_HCCA,
    FNPS_SEQ_FLAG
  } fnps_seq_state_t;

endpackage

// *** src/fnps_frame_if.sv ***
// Interface carrying frame timing between the core, the down counter and the sequencer.
`timescale 1ns/1ps
`default_nettype none
interface fnps_frame_if;
  import fnps_pkg::*;

  logic                     bitTick;
  logic                     running;
  logic                     runEnter;
  logic [FNPS_REMAIN_W-1:0] interval;
  logic                     reload;
  logic [FNPS_REMAIN_W-1:0] remaining;
  logic [FNPS_FRAME_W-1:0]  frameCount;

  modport core (
    output bitTick,
    output running,
    output runEnter,
    output interval,
    output frameCount,
    input  reload,
    input  remaining
  );

  modport ctr (
    input  bitTick,
    input  running,
    input  runEnter,
    input  interval,
    output reload,
    output remaining
  );

  modport seq (
    input  reload,
    input  frameCount
  );
endinterface
`default_nettype wire

// *** src/fnps_remaining_ctr.sv ***
// Frame-remaining down counter that marks each frame boundary with a reload pulse.
`timescale 1ns/1ps
`default_nettype none
module fnps_remaining_ctr
  import fnps_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  fnps_frame_if.ctr frameIf
);

  typedef struct packed {
    logic [FNPS_REMAIN_W-1:0] remaining;
    logic                     reload;
  } fnps_ctr_state_t;

  fnps_ctr_state_t state_reg;
  fnps_ctr_state_t state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.reload = 1'b0;
    if (frameIf.runEnter) begin
      state_next.remaining = frameIf.interval;
    end else if (frameIf.running && frameIf.bitTick) begin
      if (state_reg.remaining == REMAINING_RESET) begin
        state_next.remaining = frameIf.interval;
        state_next.reload    = 1'b1;
      end else begin
        state_next.remaining = state_reg.remaining - 14'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '{remaining: REMAINING_RESET, reload: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign frameIf.remaining = state_reg.remaining;
  assign frameIf.reload    = state_reg.reload;

endmodule
`default_nettype wire

// *** src/fnps_sof_seq.sv ***
// Per-frame sequencer: SOF, frame number store to the HCCA, then the start-of-frame flag.
`timescale 1ns/1ps
`default_nettype none
module fnps_sof_seq
  import fnps_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  fnps_frame_if.seq                    frameIf,
  input  wire logic                    hccaWrAck,
  output logic                         sofSend,
  output logic                         hccaWrReq,
  output logic [FNPS_FRAME_W-1:0]      hccaFrameNum,
  output logic                         sofFlagSet,
  output logic                         edFetchGo
);

  typedef struct packed {
    fnps_seq_state_t         st;
    logic                    sofSend;
    logic                    hccaWrReq;
    logic [FNPS_FRAME_W-1:0] hccaFrameNum;
    logic                    sofFlagSet;
    logic                    edFetchGo;
  } fnps_seq_regs_t;

  fnps_seq_regs_t state_reg;
  fnps_seq_regs_t state_next;

  always_comb begin
    state_next            = state_reg;
    state_next.sofSend    = 1'b0;
    state_next.sofFlagSet = 1'b0;
    state_next.edFetchGo  = 1'b0;
    unique case (state_reg.st)
      FNPS_SEQ_IDLE: begin
        if (frameIf.reload) begin
          state_next.sofSend = 1'b1;
          state_next.st      = FNPS_SEQ_SOF;
        end
      end
      FNPS_SEQ_SOF: begin
        state_next.hccaWrReq    = 1'b1;
        state_next.hccaFrameNum = frameIf.frameCount;
        state_next.st           = FNPS_SEQ_HCCA;
      end
      FNPS_SEQ_HCCA: begin
        if (hccaWrAck) begin
          state_next.hccaWrReq = 1'b0;
          state_next.st        = FNPS_SEQ_FLAG;
        end
      end
      FNPS_SEQ_FLAG: begin
        state_next.sofFlagSet = 1'b1;
        state_next.edFetchGo  = 1'b1;
        state_next.st         = FNPS_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '{st: FNPS_SEQ_IDLE, sofSend: 1'b0, hccaWrReq: 1'b0,
                     hccaFrameNum: FRAME_COUNT_RESET, sofFlagSet: 1'b0, edFetchGo: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sofSend      = state_reg.sofSend;
  assign hccaWrReq    = state_reg.hccaWrReq;
  assign hccaFrameNum = state_reg.hccaFrameNum;
  assign sofFlagSet   = state_reg.sofFlagSet;
  assign edFetchGo    = state_reg.edFetchGo;

endmodule
`default_nettype wire

// *** src/frame_number_periodic_start.sv ***
// Top of the frame-number counter and periodic-start comparator with its two registers.
`timescale 1ns/1ps
`default_nettype none
module frame_number_periodic_start
  import fnps_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic [FNPS_ADDR_W-1:0]   regAddr,
  input  wire logic                     regWrEn,
  input  wire logic                     regRdEn,
  input  wire logic [FNPS_DATA_W-1:0]   regWdata,
  output logic      [FNPS_DATA_W-1:0]   regRdata,
  output logic                          regRdValid,
  input  wire logic                     bitTick,
  input  wire logic                     usbRunning,
  input  wire logic [FNPS_REMAIN_W-1:0] frameInterval,
  input  wire logic                     xferBusy,
  input  wire logic                     hccaWrAck,
  output logic                          sofSend,
  output logic                          hccaWrReq,
  output logic      [FNPS_FRAME_W-1:0]  hccaFrameNum,
  output logic                          sofFlagSet,
  output logic                          edFetchGo,
  output logic      [FNPS_FRAME_W-1:0]  frameCount,
  output logic      [FNPS_REMAIN_W-1:0] remainingCount,
  output logic                          periodicPriority,
  output logic                          periodicGo
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Address match, used for both the write and the read decode.
  function automatic logic fnps_hit(input logic [FNPS_ADDR_W-1:0] addr,
                                    input logic [FNPS_ADDR_W-1:0] offset);
    fnps_hit = (addr == offset);
  endfunction

  // Read data for one address; reserved bits and unmapped addresses read as zero.
  function automatic logic [FNPS_DATA_W-1:0] fnps_read(
      input logic [FNPS_ADDR_W-1:0]   addr,
      input logic [FNPS_FRAME_W-1:0]  count,
      input logic [FNPS_REMAIN_W-1:0] threshold);
    logic [FNPS_DATA_W-1:0] data;
    data = UNMAPPED_READ_VALUE;
    if (fnps_hit(addr, FRAME_COUNT_OFFSET)) begin
      data = {16'h0000, count};
    end else if (fnps_hit(addr, PERIODIC_THRESHOLD_OFFSET)) begin
      data = {18'h00000, threshold};
    end
    fnps_read = data;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [FNPS_FRAME_W-1:0]  frameCount;
    logic [FNPS_REMAIN_W-1:0] threshold;
    logic [FNPS_DATA_W-1:0]   rdata;
    logic                     rdValid;
    logic                     runningDly;
    logic                     runEnter;
    logic                     prioHeld;
    logic                     periodicGo;
    logic [FNPS_REMAIN_W-1:0] remainingCopy;
  } fnps_core_state_t;

  fnps_core_state_t state_reg;
  fnps_core_state_t state_next;

  fnps_frame_if frameIf ();

  logic thresholdMatch;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  fnps_remaining_ctr u_remaining (
    .clk     (clk),
    .sys_rst (sys_rst),
    .frameIf (frameIf.ctr)
  );

  fnps_sof_seq u_seq (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .frameIf      (frameIf.seq),
    .hccaWrAck    (hccaWrAck),
    .sofSend      (sofSend),
    .hccaWrReq    (hccaWrReq),
    .hccaFrameNum (hccaFrameNum),
    .sofFlagSet   (sofFlagSet),
    .edFetchGo    (edFetchGo)
  );

  assign frameIf.bitTick    = bitTick;
  // The counter follows the delayed running level. This keeps it still in
  // the cycle before the entry pulse, where a tick would otherwise reload it
  // from its reset value of zero and fake a frame boundary with an SOF.
  assign frameIf.running    = state_reg.runningDly;
  assign frameIf.runEnter   = state_reg.runEnter;
  assign frameIf.interval   = frameInterval;
  assign frameIf.frameCount = state_reg.frameCount;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  assign thresholdMatch = (frameIf.remaining == state_reg.threshold);

  always_comb begin
    state_next = state_reg;

    // Entering the running state is caught as a one-cycle pulse so that the
    // count steps once, however long the running level stays high.
    state_next.runningDly = usbRunning;
    state_next.runEnter   = usbRunning && !state_reg.runningDly;

    if (frameIf.reload || state_reg.runEnter) begin
      if (state_reg.frameCount == FRAME_COUNT_MAX) begin
        state_next.frameCount = FRAME_COUNT_RESET;
      end else begin
        state_next.frameCount = state_reg.frameCount + 16'h0001;
      end
    end

    // A software write lands after the hardware step, so the written value
    // is what software later reads back.
    if (regWrEn && fnps_hit(regAddr, FRAME_COUNT_OFFSET)) begin
      state_next.frameCount = regWdata[FNPS_FRAME_W-1:0];
    end
    if (regWrEn && fnps_hit(regAddr, PERIODIC_THRESHOLD_OFFSET)) begin
      state_next.threshold = regWdata[FNPS_REMAIN_W-1:0];
    end

    state_next.rdValid = regRdEn;
    if (regRdEn) begin
      state_next.rdata = fnps_read(regAddr, state_reg.frameCount, state_reg.threshold);
    end

    if (frameIf.reload || state_reg.runEnter) begin
      state_next.prioHeld = 1'b0;
    end else if (state_reg.runningDly && thresholdMatch) begin
      state_next.prioHeld = 1'b1;
    end

    state_next.periodicGo = state_next.prioHeld && !xferBusy;

    state_next.remainingCopy = frameIf.remaining;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '{frameCount:    FRAME_COUNT_RESET,
                     threshold:     THRESHOLD_RESET,
                     rdata:         UNMAPPED_READ_VALUE,
                     rdValid:       1'b0,
                     runningDly:    1'b0,
                     runEnter:      1'b0,
                     prioHeld:      1'b0,
                     periodicGo:    1'b0,
                     remainingCopy: REMAINING_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata         = state_reg.rdata;
  assign regRdValid       = state_reg.rdValid;
  assign frameCount       = state_reg.frameCount;
  assign remainingCount   = state_reg.remainingCopy;
  assign periodicPriority = state_reg.prioHeld;
  assign periodicGo       = state_reg.periodicGo;

endmodule
`default_nettype wire

// *** test/fnps_properties.sv ***
// Port-level checker of the frame-number and periodic-start block.
`timescale 1ns/1ps
`default_nettype none
module fnps_checker
  import fnps_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     sys_rst,
  input wire logic [FNPS_ADDR_W-1:0]   regAddr,
  input wire logic                     regWrEn,
  input wire logic                     regRdEn,
  input wire logic [FNPS_DATA_W-1:0]   regWdata,
  input wire logic [FNPS_DATA_W-1:0]   regRdata,
  input wire logic                     regRdValid,
  input wire logic                     hccaWrAck,
  input wire logic                     sofSend,
  input wire logic                     hccaWrReq,
  input wire logic [FNPS_FRAME_W-1:0]  hccaFrameNum,
  input wire logic                     sofFlagSet,
  input wire logic                     edFetchGo,
  input wire logic [FNPS_FRAME_W-1:0]  frameCount,
  input wire logic [FNPS_REMAIN_W-1:0] remainingCount,
  input wire logic                     periodicPriority,
  input wire logic                     periodicGo
);
  logic [FNPS_REMAIN_W-1:0] thrMirror_reg;

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // The threshold is not a port, so it is rebuilt from the writes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      thrMirror_reg <= 14'h0000;
    end else if (regWrEn && regAddr == PERIODIC_THRESHOLD_OFFSET) begin
      thrMirror_reg <= regWdata[13:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_RD_FRAME: assert property (regRdEn && !regWrEn && regAddr == FRAME_COUNT_OFFSET
    |=> regRdValid && regRdata == {16'h0000, $past(frameCount)})
    else $error("frame count read returned a wrong word");
  AST_RD_THRESHOLD: assert property (regRdEn && !regWrEn
    && regAddr == PERIODIC_THRESHOLD_OFFSET |=> regRdata == {18'h00000, thrMirror_reg})
    else $error("threshold read returned a wrong word");
  AST_SOF_INC: assert property (sofSend |-> frameCount == $past(frameCount) + 16'h0001)
    else $error("frame count did not step with the boundary");
  AST_HCCA_REQ: assert property ($rose(sofSend) |=> $rose(hccaWrReq)
    && hccaFrameNum == frameCount)
    else $error("store request did not follow the SOF");
  AST_REQ_HOLD: assert property (hccaWrReq && !hccaWrAck |=> hccaWrReq
    && $stable(hccaFrameNum))
    else $error("store request dropped before its acknowledge");
  AST_FLAG: assert property (hccaWrReq && hccaWrAck |=> !hccaWrReq ##1 (sofFlagSet && edFetchGo))
    else $error("start-of-frame flag missing after the store");
  AST_PRIO_MATCH: assert property ($rose(periodicPriority) |-> remainingCount == thrMirror_reg)
    else $error("priority rose away from the threshold");
  AST_GO: assert property (periodicGo |-> periodicPriority)
    else $error("periodic start without priority");
  AST_PRIO_CLEAR: assert property (sofSend |-> !periodicPriority)
    else $error("priority survived the frame boundary");
endmodule

bind frame_number_periodic_start fnps_checker chk (.clk(clk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWdata(regWdata),
  .regRdata(regRdata), .regRdValid(regRdValid), .hccaWrAck(hccaWrAck), .sofSend(sofSend),
  .hccaWrReq(hccaWrReq), .hccaFrameNum(hccaFrameNum), .sofFlagSet(sofFlagSet),
  .edFetchGo(edFetchGo), .frameCount(frameCount), .remainingCount(remainingCount),
  .periodicPriority(periodicPriority), .periodicGo(periodicGo));
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking testbench of the frame-number and periodic-start block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fnps_pkg::*;
  localparam logic [13:0] TB_INTERVAL = 14'h0014;
  logic        clk = 1'b0, bitTick = 1'b0, hccaWrAck = 1'b0;
  logic        sys_rst, regWrEn, regRdEn, regRdValid, usbRunning;
  logic        xferBusy, sofSend, hccaWrReq, sofFlagSet, edFetchGo;
  logic        periodicPriority, periodicGo;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata;
  logic [15:0] hccaFrameNum, frameCount;
  logic [13:0] remainingCount;
  logic [2:0]  ackWait = 3'h0;
  int          error_cnt, num_checks;

  frame_number_periodic_start uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWdata(regWdata), .regRdata(regRdata),
    .regRdValid(regRdValid), .bitTick(bitTick), .usbRunning(usbRunning),
    .frameInterval(TB_INTERVAL), .xferBusy(xferBusy), .hccaWrAck(hccaWrAck),
    .sofSend(sofSend), .hccaWrReq(hccaWrReq), .hccaFrameNum(hccaFrameNum),
    .sofFlagSet(sofFlagSet), .edFetchGo(edFetchGo), .frameCount(frameCount),
    .remainingCount(remainingCount), .periodicPriority(periodicPriority),
    .periodicGo(periodicGo));

  // ----------------------------------------------------------------
  // Clock, bit ticks and a memory side that acknowledges late
  // ----------------------------------------------------------------
  always #12.5 clk = ~clk;
  // A slow acknowledge keeps the store request waiting for some cycles.
  always @(posedge clk) begin
    bitTick <= ~bitTick;
    ackWait <= hccaWrReq ? ackWait + 3'h1 : 3'h0;
    hccaWrAck <= hccaWrReq && !hccaWrAck && ackWait == 3'h3;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    chk({31'h0, regRdValid}, 32'h1);
    chk(regRdata, exp);
  endtask
  // Waits after each edge for SOF, store request, flag or priority.
  task automatic wait_hi(input int sel);
    int   n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 300) begin
      @(posedge clk);
      #1;
      n++;
      case (sel)
        0: hit = sofSend === 1'b1;
        1: hit = hccaWrReq === 1'b1;
        2: hit = sofFlagSet === 1'b1;
        default: hit = periodicPriority === 1'b1;
      endcase
    end
    chk({31'h0, hit}, 32'h1);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {regWrEn, regRdEn, usbRunning, xferBusy} = 4'h0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    error_cnt = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(FRAME_COUNT_OFFSET, 32'h0);
    rd_chk(PERIODIC_THRESHOLD_OFFSET, 32'h0);
    $display("test reset_values done");
    wr(PERIODIC_THRESHOLD_OFFSET, 32'h0000_3e67);
    rd_chk(PERIODIC_THRESHOLD_OFFSET, 32'h0000_3e67);
    wr(8'h44, 32'h0000_1234);
    rd_chk(8'h44, 32'h0);
    wr(FRAME_COUNT_OFFSET, 32'h0000_fff0);
    rd_chk(FRAME_COUNT_OFFSET, 32'h0000_fff0);
    wr(PERIODIC_THRESHOLD_OFFSET, 32'h0000_0005);
    $display("test register_access done");
    @(posedge clk);
    xferBusy <= 1'b1;
    usbRunning <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({16'h0, frameCount}, 32'h0000_fff1);
    wait_hi(3);
    chk({18'h0, remainingCount}, 32'h0000_0005);
    chk({31'h0, periodicGo}, 32'h0);
    @(posedge clk);
    xferBusy <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, periodicGo}, 32'h1);
    wait_hi(0);
    chk({16'h0, frameCount}, 32'h0000_fff2);
    chk({18'h0, remainingCount}, {18'h0, TB_INTERVAL});
    chk({31'h0, periodicPriority}, 32'h0);
    wait_hi(1);
    chk({16'h0, hccaFrameNum}, 32'h0000_fff2);
    wait_hi(2);
    chk({31'h0, edFetchGo}, 32'h1);
    $display("test first_frame done");
    wr(FRAME_COUNT_OFFSET, 32'h0000_ffff);
    wait_hi(0);
    chk({16'h0, frameCount}, 32'h0);
    wait_hi(2);
    rd_chk(FRAME_COUNT_OFFSET, 32'h0);
    chk({16'h0001, regRdata[15:0]}, 32'h0001_0000);
    $display("test wrap done");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(PERIODIC_THRESHOLD_OFFSET, 32'h0);
    $display("test mid_reset done");
    final_report;
  end

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired at %0t ns", $time);
    final_report;
  end
endmodule
`default_nettype wire
